/* File: design/rsc_core.sv */
`timescale 1ns/100ps
module rsc_core import rsc_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
  input  wire logic              ref_clk,                // Control clock
  input  wire logic              rst,                    // Sync reset, high
  input  wire logic              reclose_request_p1,     // Request, highest priority
  input  wire logic              reclose_request_p2,     // Request 2
  input  wire logic              reclose_request_p3,     // Request 3
  input  wire logic              reclose_request_p4,     // Request 4
  input  wire logic              reclose_request_p5,     // Request, lowest priority
  input  wire logic              sequencer_enable_in,    // On/off input
  input  wire logic              use_enable_input,       // Honour on/off input
  input  wire logic              manual_unlock_in,       // Manual reset
  input  wire logic              force_lock_in,          // Lock input
  input  wire logic              critical_lock_request,  // Critical request
  input  wire logic              objectConfigured,       // Breaker object present
  input  wire logic              breakerOpen,            // Breaker open status
  input  wire logic              breakerClosed,          // Breaker closed status
  input  wire logic              manualOpen,             // Manual open seen
  input  wire logic              manualClose,            // Manual close seen
  input  wire logic              objectFail,             // Failure report
  input  wire logic [2:0]        shotCount,              // Shots in scheme, 0..5
  input  wire logic [NREQ-1:0]   shotUseArcing,          // Per shot: 1 arcing, 0 discrimination
  input  wire logic [TIME_W-1:0] deadTimeMs,             // Dead time
  input  wire logic [TIME_W-1:0] reclaimTimeMs,          // Shot reclaim time
  input  wire logic [TIME_W-1:0] shot_supervision_limit, // Arcing limit
  input  wire logic [TIME_W-1:0] discrimTimeMs,          // Discrimination window
  input  wire logic [TIME_W-1:0] genReclaimTimeMs,       // General reclaim time
  input  wire logic              useGenReclaim,          // Enter general reclaim on success
  input  wire logic [EVT_N-1:0]  eventEnable,            // Per event type enable
  input  wire logic [NCNT-1:0]   counterClear,           // Per counter clear
  input  wire logic [3:0]        counterSelect,          // Counter read select
  output logic                   objectOpenCmd,          // Open command
  output logic                   objectCloseCmd,         // Close command
  output logic                   arOn,                   // Sequencer enabled
  output logic                   readyOut,               // Ready
  output logic                   runningOut,             // Running
  output logic                   inProgress,             // Opened, heading to close
  output logic                   deadTimeOn,             // Dead timer running
  output logic                   arcingTimeOn,           // Arcing timer running
  output logic                   reclaimTimeOn,          // Reclaim timer running
  output logic                   genReclaimOn,           // General reclaim running
  output logic                   seqFinished,            // Closed after last shot
  output logic                   finalTripOut,           // Final trip issued
  output logic                   lockedOut,              // Locked
  output logic                   haltedOut,              // Halted by discrimination
  output logic [2:0]             shotRunning,            // Current shot, 0 none
  output logic [2:0]             requestOn,              // Served request, 0 none
  output logic                   followerOpen,           // Follower breaker hold-open
  output logic                   followerClosePermit,    // Follower close permission
  output logic                   eventValid,             // Event record strobe
  output logic [3:0]             eventCode,              // Event source
  output logic                   eventLevel,             // New level of source
  output logic [STAMP_W-1:0]     eventStamp,             // Time stamp in ms
  output logic [CNT_W-1:0]       counterValue            // Selected counter
);

  function automatic logic [3:0] lowestSet(input logic [EVT_N-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = EVT_N - 1; i >= 0; i--) begin
      if (v[i]) r = 4'(i);
    end
    return r;
  endfunction

  logic                  msTick;
  rsc_state_type         stateReg, stateNext;
  logic [TIME_W-1:0]     timerReg, arcAccReg;
  logic [2:0]            shotReg, shotNext, reqIdxReg, reqIdxNext;
  logic                  lockGenReg, lockGenNext, unlockSeenReg;
  logic [NREQ-1:0]       reqVec;
  logic                  anyReq, blocked, arcMode, reqStart, permitNow, successNow;
  logic [CNT_W-1:0]      cntReg [NCNT];
  logic [NCNT-1:0]       cntBump;
  logic [STAMP_W-1:0]    msCountReg;
  logic [EVT_N-1:0]      evtNow, evtPrevReg, pendReg;
  logic [3:0]            evtIdx;

  rsc_ms_tick #(
    .DIV(TICK_CYCLES)
  ) uTick (
    .ref_clk(ref_clk),
    .rst    (rst),
    .msTick (msTick)
  );

  assign reqVec  = {reclose_request_p5, reclose_request_p4, reclose_request_p3,
                    reclose_request_p2, reclose_request_p1};
  assign anyReq  = |reqVec;
  assign blocked = !objectConfigured || (use_enable_input && !sequencer_enable_in);
  // Shots count from 1, selector bits from 0
  assign arcMode = (shotReg != 3'h0) && shotUseArcing[3'(shotReg - 3'h1)];

  always_comb begin
    stateNext   = stateReg;
    shotNext    = shotReg;
    reqIdxNext  = reqIdxReg;
    lockGenNext = lockGenReg;
    reqStart    = 1'b0;
    permitNow   = 1'b0;
    successNow  = 1'b0;
    if (blocked) begin
      stateNext = ST_OFF;
    end else if (critical_lock_request) begin
      stateNext = ST_LOCKED;
    end else if (force_lock_in) begin
      stateNext = ST_LOCKED;
    end else if ((manualOpen || manualClose) && stateReg inside
                 {ST_OPENING, ST_DEAD, ST_CLOSING, ST_RECLAIM, ST_GENRECL, ST_FINAL}) begin
      if (stateReg == ST_DEAD && manualClose) begin
        stateNext   = ST_GENRECL;
        lockGenNext = 1'b1;
      end else begin
        stateNext = ST_READY;
      end
    end else if (objectFail && stateReg inside {ST_OPENING, ST_CLOSING, ST_FINAL}) begin
      stateNext = ST_LOCKED;
    end else begin
      unique case (stateReg)
        ST_OFF: stateNext = ST_READY;
        ST_READY: begin
          if (anyReq && shotCount != 3'h0) begin
            stateNext   = ST_OPENING;
            shotNext    = 3'h1;
            reqIdxNext  = 3'(lowestSet(EVT_N'(reqVec)) + 4'h1);
            lockGenNext = 1'b0;
            reqStart    = 1'b1;
          end
        end
        ST_OPENING: if (breakerOpen) stateNext = ST_DEAD;
        ST_DEAD: if (timerReg >= deadTimeMs) stateNext = ST_CLOSING;
        ST_CLOSING: if (breakerClosed) stateNext = ST_RECLAIM;
        ST_RECLAIM: begin
          if (anyReq && !arcMode && timerReg < discrimTimeMs) begin
            stateNext = ST_HALTED;
          end else if (anyReq && (!arcMode || arcAccReg >= shot_supervision_limit)) begin
            if (shotReg < shotCount) begin
              shotNext  = 3'(shotReg + 3'h1);
              stateNext = ST_OPENING;
            end else begin
              stateNext = ST_FINAL;
            end
          end else if (timerReg >= reclaimTimeMs) begin
            successNow = 1'b1;
            if (useGenReclaim) begin
              stateNext = ST_GENRECL;
            end else begin
              stateNext = ST_READY;
              permitNow = 1'b1;
            end
          end
        end
        ST_GENRECL: begin
          if (anyReq) begin
            stateNext = ST_FINAL;
          end else if (timerReg >= genReclaimTimeMs) begin
            stateNext = lockGenReg ? ST_LOCKED : ST_READY;
            permitNow = !lockGenReg;
          end
        end
        ST_FINAL: if (breakerOpen) stateNext = ST_LOCKED;
        ST_LOCKED: if (manual_unlock_in) stateNext = ST_READY;
        // Unlock, then manual close
        ST_HALTED: if (unlockSeenReg && manualClose) stateNext = ST_READY;
      endcase
    end
    if (stateNext inside {ST_READY, ST_OFF, ST_LOCKED, ST_HALTED}) begin
      shotNext   = 3'h0;
      reqIdxNext = 3'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stateReg   <= ST_OFF;
      shotReg    <= 3'h0;
      reqIdxReg  <= 3'h0;
      lockGenReg <= 1'b0;
    end else begin
      stateReg   <= stateNext;
      shotReg    <= shotNext;
      reqIdxReg  <= reqIdxNext;
      lockGenReg <= lockGenNext;
    end
  end

  // Restarts on each state change; saturates rather than wrap
  always_ff @(posedge ref_clk) begin
    if (rst || stateNext != stateReg) begin
      timerReg <= '0;
    end else if (msTick && timerReg != '1) begin
      timerReg <= timerReg + 1'b1;
    end
  end

  // Accumulates over the reclaim period; a request drop keeps it
  always_ff @(posedge ref_clk) begin
    if (rst || stateReg != ST_RECLAIM) begin
      arcAccReg <= '0;
    end else if (msTick && anyReq && arcMode && arcAccReg != '1) begin
      arcAccReg <= arcAccReg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || stateReg != ST_HALTED) begin
      unlockSeenReg <= 1'b0;
    end else if (manual_unlock_in) begin
      unlockSeenReg <= 1'b1;
    end
  end

  // Outputs decode the next state to line up with the state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      objectOpenCmd  <= 1'b0;
      objectCloseCmd <= 1'b0;
      arOn           <= 1'b0;
      readyOut       <= 1'b0;
      runningOut     <= 1'b0;
      inProgress     <= 1'b0;
      deadTimeOn     <= 1'b0;
      arcingTimeOn   <= 1'b0;
      reclaimTimeOn  <= 1'b0;
      genReclaimOn   <= 1'b0;
      seqFinished    <= 1'b0;
      finalTripOut   <= 1'b0;
      lockedOut      <= 1'b0;
      haltedOut      <= 1'b0;
      shotRunning    <= 3'h0;
      requestOn      <= 3'h0;
    end else begin
      objectOpenCmd  <= stateNext inside {ST_OPENING, ST_FINAL};
      objectCloseCmd <= stateNext == ST_CLOSING;
      arOn           <= stateNext != ST_OFF;
      readyOut       <= stateNext == ST_READY;
      runningOut     <= stateNext inside {ST_OPENING, ST_DEAD, ST_CLOSING, ST_RECLAIM};
      inProgress     <= stateNext inside {ST_OPENING, ST_DEAD};
      deadTimeOn     <= stateNext == ST_DEAD;
      arcingTimeOn   <= stateNext == ST_RECLAIM && stateReg == ST_RECLAIM && arcMode && anyReq;
      reclaimTimeOn  <= stateNext == ST_RECLAIM;
      genReclaimOn   <= stateNext == ST_GENRECL;
      seqFinished    <= stateNext == ST_RECLAIM && shotNext == shotCount;
      finalTripOut   <= stateNext == ST_FINAL;
      lockedOut      <= stateNext == ST_LOCKED;
      haltedOut      <= stateNext == ST_HALTED;
      shotRunning    <= shotNext;
      requestOn      <= reqIdxNext;
    end
  end

  // Follower held open until close permission
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      followerOpen        <= 1'b0;
      followerClosePermit <= 1'b0;
    end else if (reqStart) begin
      followerOpen        <= 1'b1;
      followerClosePermit <= 1'b0;
    end else if (permitNow) begin
      followerOpen        <= 1'b0;
      followerClosePermit <= 1'b1;
    end
  end

  always_comb begin
    cntBump = '0;
    if (reqStart) cntBump[3'(reqIdxNext - 3'h1)] = 1'b1;
    cntBump[CNT_SHOT]    = stateNext == ST_CLOSING && stateReg != ST_CLOSING;
    cntBump[CNT_SUCCESS] = successNow;
    cntBump[CNT_FINAL]   = stateNext == ST_FINAL && stateReg != ST_FINAL;
    cntBump[CNT_LOCK]    = stateNext == ST_LOCKED && stateReg != ST_LOCKED;
  end

  // Clear with a same-cycle event leaves one
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NCNT; i++) begin
      if (rst) begin
        cntReg[i] <= '0;
      end else if (counterClear[i]) begin
        cntReg[i] <= CNT_W'(cntBump[i]);
      end else if (cntBump[i] && cntReg[i] != '1) begin
        cntReg[i] <= cntReg[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      counterValue <= '0;
    end else if (counterSelect < 4'(NCNT)) begin
      counterValue <= cntReg[counterSelect];
    end else begin
      counterValue <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      msCountReg <= '0;
    end else if (msTick) begin
      msCountReg <= msCountReg + 1'b1;
    end
  end

  always_comb begin
    evtNow              = '0;
    evtNow[EV_OPEN]     = objectOpenCmd;
    evtNow[EV_CLOSE]    = objectCloseCmd;
    evtNow[EV_REQ+:NREQ] = reqVec;
    evtNow[EV_ENABLE]   = sequencer_enable_in;
    evtNow[EV_UNLOCK]   = manual_unlock_in;
    evtNow[EV_FLOCK]    = force_lock_in;
    evtNow[EV_CRIT]     = critical_lock_request;
    evtNow[EV_RUN]      = runningOut;
    evtNow[EV_LOCKED]   = lockedOut;
    evtNow[EV_FINAL]    = finalTripOut;
    evtNow[EV_HALT]     = haltedOut;
    evtNow[EV_MANUAL]   = manualOpen || manualClose;
  end

  assign evtIdx = lowestSet(pendReg);

  // Pending bits drain one per cycle; a new change beats the serve-clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evtPrevReg <= '0;
      pendReg    <= '0;
      eventValid <= 1'b0;
      eventCode  <= 4'h0;
      eventLevel <= 1'b0;
      eventStamp <= '0;
    end else begin
      evtPrevReg <= evtNow;
      pendReg    <= (pendReg & ~(EVT_N'(|pendReg) << evtIdx)) |
                    ((evtNow ^ evtPrevReg) & eventEnable);
      eventValid <= |pendReg;
      eventCode  <= evtIdx;
      eventLevel <= evtNow[evtIdx];
      eventStamp <= msCountReg;
    end
  end
endmodule

/* File: include/rsc_pkg.sv */
// Summary of operation
// - Reclaim follows the close; a request in it takes next shot or final trip.
// - Each shot uses either arcing or discrimination supervision.
// - Arcing shot: request time in reclaim reaching the limit fails the shot.
// - Request dropping before the arcing limit lets reclaim go on.
// - Reclaim expiry marks success, then general reclaim or ready.
// - Arcing time accumulates over one reclaim period.
// - Request in the discrimination window halts until unlock and manual close.
// - Drive open and close commands plus status indications.
// - Log time-stamped on/off events with 1 ms resolution.
// - One clearable counter per reclosing event kind and per request.
// - Manual operation resets the sequence; manual close in dead time locks out.
// - Object controller failure during open or close locks out.
// - Sequencer stays off unless a breaker object is configured.
// - Changes of commands, requests, control inputs and the running, locked, final and halt outputs record events; each type is enabled separately.
// - Enable input counts only when use-enable-input is set.
// - Manual unlock releases the locked state.
// - Lock input forces locked; return to ready needs manual unlock.
// - Critical request locks at once, with no shot.
// - Fixed priority, request one highest.
// - An active request with all conditions met starts a shot.
// - Follower held open during sequence; close granted after successful reclaim.
// - Settings are live ports; a group change applies at once.
// - A timer set to zero is skipped.
// - Request in general reclaim goes to final trip, then lock-out.
package rsc_pkg;
  localparam int TICK_US         = 1000;
  localparam int CLK_MHZ         = 200;
  localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
  localparam int TIME_W  = 20;
  localparam int STAMP_W = 32;
  localparam int CNT_W   = 16;
  localparam int NREQ    = 5;
  localparam int EVT_N   = 16;
  localparam int NCNT    = 9;
  // Counter slots 0..4 are the requests
  localparam int CNT_SHOT    = 5;
  localparam int CNT_SUCCESS = 6;
  localparam int CNT_FINAL   = 7;
  localparam int CNT_LOCK    = 8;
  // Event source bit positions
  localparam int EV_OPEN   = 0;
  localparam int EV_CLOSE  = 1;
  localparam int EV_REQ    = 2;
  localparam int EV_ENABLE = 7;
  localparam int EV_UNLOCK = 8;
  localparam int EV_FLOCK  = 9;
  localparam int EV_CRIT   = 10;
  localparam int EV_RUN    = 11;
  localparam int EV_LOCKED = 12;
  localparam int EV_FINAL  = 13;
  localparam int EV_HALT   = 14;
  localparam int EV_MANUAL = 15;
  typedef enum logic [3:0] {
    ST_OFF     = 4'h0,
    ST_READY   = 4'h1,
    ST_OPENING = 4'h2,
    ST_DEAD    = 4'h3,
    ST_CLOSING = 4'h4,
    ST_RECLAIM = 4'h5,
    ST_GENRECL = 4'h6,
    ST_FINAL   = 4'h7,
    ST_LOCKED  = 4'h8,
    ST_HALTED  = 4'h9
  } rsc_state_type;
endpackage

/* File: design/rsc_ms_tick.sv */
`timescale 1ns/100ps
module rsc_ms_tick #(
  parameter int DIV = 200000
)(
  input  wire logic ref_clk, // Control clock
  input  wire logic rst,     // Sync reset, high
  output logic      msTick   // Pulse every DIV clocks
);
  logic [31:0] divReg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      divReg <= 32'h0;
      msTick <= 1'b0;
    end else if (divReg == 32'(DIV - 1)) begin
      divReg <= 32'h0;
      msTick <= 1'b1;
    end else begin
      divReg <= divReg + 32'h1;
      msTick <= 1'b0;
    end
  end
endmodule

/* File: testbench/rsc_core_asserts.sv */
`timescale 1ns/100ps
module rsc_core_asserts import rsc_pkg::*; (
  input wire logic       ref_clk,               // Clock
  input wire logic       rst,                   // Reset
  input wire logic       reclose_request_p1,    // Request 1
  input wire logic       reclose_request_p2,    // Request 2
  input wire logic       reclose_request_p3,    // Request 3
  input wire logic       reclose_request_p4,    // Request 4
  input wire logic       reclose_request_p5,    // Request 5
  input wire logic       sequencer_enable_in,   // On/off
  input wire logic       use_enable_input,      // On/off in use
  input wire logic       manual_unlock_in,      // Unlock
  input wire logic       force_lock_in,         // Lock
  input wire logic       critical_lock_request, // Critical
  input wire logic       objectConfigured,      // Object present
  input wire logic       breakerOpen,           // Breaker open
  input wire logic       manualOpen,            // Manual open
  input wire logic       manualClose,           // Manual close
  input wire logic       objectFail,            // Failure report
  input wire logic [2:0] shotCount,             // Shots
  input wire logic       objectOpenCmd,         // Open command
  input wire logic       objectCloseCmd,        // Close command
  input wire logic       arOn,                  // Enabled
  input wire logic       readyOut,              // Ready
  input wire logic       runningOut,            // Running
  input wire logic       deadTimeOn,            // Dead time
  input wire logic       lockedOut,             // Locked
  input wire logic       haltedOut,             // Halted
  input wire logic [2:0] requestOn              // Served request
);
  logic       cfgOn;
  logic       startOk;
  logic       quiet;
  logic [2:0] prioIdx;
  assign cfgOn   = objectConfigured && (!use_enable_input || sequencer_enable_in);
  assign quiet   = !manualOpen && !manualClose && !objectFail;
  assign startOk = readyOut && cfgOn && shotCount != 3'h0 && !critical_lock_request && !force_lock_in && quiet;
  assign prioIdx = reclose_request_p1 ? 3'h1 : reclose_request_p2 ? 3'h2 : reclose_request_p3 ? 3'h3 :
                   reclose_request_p4 ? 3'h4 : reclose_request_p5 ? 3'h5 : 3'h0;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_START: assert property (startOk && prioIdx != 3'h0 |=> objectOpenCmd && runningOut)
    else $error("Start did not open");
  AST_PRIO: assert property (startOk && prioIdx != 3'h0 |=> requestOn == $past(prioIdx))
    else $error("Wrong request served");
  AST_OFF: assert property (!objectConfigured |=> !readyOut && !runningOut && !objectOpenCmd)
    else $error("Active without object");
  AST_ENIN: assert property (objectConfigured && use_enable_input && !sequencer_enable_in |=> !arOn && !readyOut)
    else $error("Disable input ignored");
  AST_CRIT: assert property (readyOut && cfgOn && critical_lock_request |=> lockedOut && !objectOpenCmd)
    else $error("Critical did not lock");
  AST_FLOCK: assert property (readyOut && cfgOn && force_lock_in && !critical_lock_request |=> lockedOut)
    else $error("Lock input did not lock");
  AST_HOLD: assert property (lockedOut && force_lock_in |=> !readyOut)
    else $error("Ready while locked");
  AST_UNLOCK: assert property (lockedOut && manual_unlock_in && cfgOn && !force_lock_in && !critical_lock_request
                               && quiet |=> readyOut)
    else $error("Unlock failed");
  AST_HALT: assert property (haltedOut && !manualClose |=> !objectOpenCmd && !objectCloseCmd)
    else $error("Command while halted");
  AST_EXCL: assert property (!(objectOpenCmd && objectCloseCmd))
    else $error("Open and close together");
  AST_OPENDROP: assert property (objectOpenCmd && breakerOpen |=> !objectOpenCmd)
    else $error("Open kept after opening");
  AST_CLOSEDEAD: assert property ($rose(objectCloseCmd) |-> $past(deadTimeOn))
    else $error("Close without dead time");
endmodule
bind rsc_core rsc_core_asserts uChk (.*);

/* File: testbench/rsc_breaker_model.sv */
`timescale 1ns/100ps
module rsc_breaker_model #(
  parameter int DELAY = 4
)(
  input wire logic ref_clk,               // Clock
  input wire logic rst,                   // Reset
  input wire logic objectOpenCmd,         // Open command
  input wire logic objectCloseCmd,        // Close command
  input wire logic manualOpen,            // Manual open
  input wire logic manualClose,           // Manual close
  input wire logic failNext,              // Fail every close while set
  output logic     breakerOpen   = 1'b0,  // Open status
  output logic     breakerClosed = 1'b1,  // Closed status
  output logic     objectFail    = 1'b0   // Failure report
);
  int opCnt = 0;
  // Travel takes DELAY+1 cycles; the command must be held
  always @(negedge ref_clk) begin
    objectFail <= !rst && !manualClose && !manualOpen && objectCloseCmd && failNext && opCnt == DELAY;
    if (rst || manualClose) begin
      breakerOpen   <= 1'b0;
      breakerClosed <= 1'b1;
      opCnt         <= 0;
    end else if (manualOpen) begin
      breakerOpen   <= 1'b1;
      breakerClosed <= 1'b0;
    end else if (objectOpenCmd || objectCloseCmd) begin
      opCnt <= (opCnt == DELAY) ? 0 : opCnt + 1;
      if (opCnt == DELAY && !(objectCloseCmd && failNext)) begin
        breakerOpen   <= objectOpenCmd;
        breakerClosed <= objectCloseCmd;
      end
    end else begin
      opCnt <= 0;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
`define WAITC(c) begin for (int w = 0; w < 3000 && !(c); w++) @(negedge ref_clk); end
module tb_top import rsc_pkg::*; ;
  logic               ref_clk = 1'b0, rst = 1'b1, useGenReclaim = 1'b0, failNext = 1'b0;
  logic [4:0]         reqV = 5'h00;
  wire                reclose_request_p1 = reqV[0], reclose_request_p2 = reqV[1], reclose_request_p3 = reqV[2];
  wire                reclose_request_p4 = reqV[3], reclose_request_p5 = reqV[4];
  logic               sequencer_enable_in = 1'b0, use_enable_input = 1'b0, manual_unlock_in = 1'b0;
  logic               force_lock_in = 1'b0, critical_lock_request = 1'b0, objectConfigured = 1'b1;
  logic               manualOpen = 1'b0, manualClose = 1'b0, breakerOpen, breakerClosed, objectFail;
  logic [2:0]         shotCount = 3'h2, shotRunning, requestOn;
  logic [NREQ-1:0]    shotUseArcing = 5'h1f;
  logic [TIME_W-1:0]  deadTimeMs = 20'h3, reclaimTimeMs = 20'ha, shot_supervision_limit = 20'h4;
  logic [TIME_W-1:0]  discrimTimeMs = 20'h3, genReclaimTimeMs = 20'h5;
  logic [EVT_N-1:0]   eventEnable = 16'hffff;
  logic [NCNT-1:0]    counterClear = 9'h0;
  logic [3:0]         counterSelect = 4'h0, eventCode;
  logic               objectOpenCmd, objectCloseCmd, arOn, readyOut, runningOut, inProgress, deadTimeOn;
  logic               arcingTimeOn, reclaimTimeOn, genReclaimOn, seqFinished, finalTripOut, lockedOut, haltedOut;
  logic               followerOpen, followerClosePermit, eventValid, eventLevel;
  logic [STAMP_W-1:0] eventStamp, stampA;
  logic [CNT_W-1:0]   counterValue;
  int                 n_fail = 0, compares = 0;
  // Fast tick for simulation
  rsc_core #(.TICK_CYCLES(10)) uut (.*);
  rsc_breaker_model #(.DELAY(4)) partner (.*);
  always #2.5 ref_clk = ~ref_clk;
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic done(input string s);
    $display("test %0s done", s);
  endtask
  task automatic unlock();
    manual_unlock_in = 1'b1;
    tick(2);
    manual_unlock_in = 1'b0;
    tick(2);
  endtask
  task automatic shot(input logic [4:0] r, input logic [2:0] e);
    reqV = r;
    tick(2);
    `CHK(requestOn, e)
    reqV = 5'h00;
    `WAITC(reclaimTimeOn)
  endtask
  task automatic cnt(input logic [3:0] i, input logic [CNT_W-1:0] e);
    counterSelect = i;
    tick(2);
    `CHK(counterValue, e)
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
  initial begin
    int k;
    tick(10);
    rst = 1'b0;
    tick(3);
    `CHK(readyOut, 1'b1)
    objectConfigured = 1'b0;
    reqV = 5'h01;
    tick(3);
    `CHK(readyOut, 1'b0)
    `CHK(objectOpenCmd, 1'b0)
    reqV = 5'h00;
    objectConfigured = 1'b1;
    use_enable_input = 1'b1;
    tick(3);
    `CHK(arOn, 1'b0)
    sequencer_enable_in = 1'b1;
    tick(3);
    `CHK(readyOut, 1'b1)
    use_enable_input = 1'b0;
    sequencer_enable_in = 1'b0;
    tick(3);
    `CHK(readyOut, 1'b1)
    done("enable");
    shot(5'h06, 3'h2);
    `CHK(followerOpen, 1'b1)
    `WAITC(readyOut)
    `CHK(followerClosePermit, 1'b1)
    cnt(4'h1, 16'h1);
    cnt(4'(CNT_SUCCESS), 16'h1);
    counterClear = 9'h2;
    tick(1);
    counterClear = 9'h0;
    cnt(4'h1, 16'h0);
    done("success");
    shot(5'h01, 3'h1);
    reqV = 5'h01;
    tick(20);
    reqV = 5'h00;
    tick(2);
    `CHK(reclaimTimeOn, 1'b1)
    reqV = 5'h01;
    tick(30);
    reqV = 5'h00;
    `CHK(shotRunning, 3'h2)
    `WAITC(reclaimTimeOn)
    reqV = 5'h01;
    `WAITC(finalTripOut)
    `CHK(finalTripOut, 1'b1)
    reqV = 5'h00;
    `WAITC(lockedOut)
    `CHK(lockedOut, 1'b1)
    cnt(4'(CNT_FINAL), 16'h1);
    unlock();
    `CHK(readyOut, 1'b1)
    done("arcing");
    shotUseArcing = 5'h00;
    shot(5'h10, 3'h5);
    reqV = 5'h10;
    tick(3);
    reqV = 5'h00;
    `CHK(haltedOut, 1'b1)
    unlock();
    `CHK(readyOut, 1'b0)
    manualClose = 1'b1;
    tick(1);
    manualClose = 1'b0;
    tick(3);
    `CHK(readyOut, 1'b1)
    done("discrimination");
    shotUseArcing = 5'h1f;
    useGenReclaim = 1'b1;
    shot(5'h01, 3'h1);
    `WAITC(genReclaimOn)
    reqV = 5'h01;
    `WAITC(finalTripOut)
    `CHK(finalTripOut, 1'b1)
    reqV = 5'h00;
    `WAITC(lockedOut)
    `CHK(lockedOut, 1'b1)
    unlock();
    useGenReclaim = 1'b0;
    critical_lock_request = 1'b1;
    tick(1);
    critical_lock_request = 1'b0;
    tick(2);
    `CHK(lockedOut, 1'b1)
    `CHK(runningOut, 1'b0)
    unlock();
    force_lock_in = 1'b1;
    unlock();
    `CHK(lockedOut, 1'b1)
    force_lock_in = 1'b0;
    unlock();
    `CHK(readyOut, 1'b1)
    done("locking");
    deadTimeMs = 20'h14;
    reqV = 5'h01;
    tick(2);
    reqV = 5'h00;
    `WAITC(deadTimeOn)
    manualClose = 1'b1;
    tick(1);
    manualClose = 1'b0;
    tick(3);
    `CHK(genReclaimOn, 1'b1)
    `WAITC(lockedOut)
    `CHK(lockedOut, 1'b1)
    unlock();
    deadTimeMs = 20'h0;
    reqV = 5'h01;
    tick(2);
    reqV = 5'h00;
    `WAITC(breakerOpen)
    tick(3);
    `CHK(objectCloseCmd, 1'b1)
    `WAITC(readyOut)
    deadTimeMs = 20'h3;
    done("manual and zero");
    force_lock_in = 1'b1;
    eventEnable = 16'h0040;
    tick(30);
    reqV = 5'h18;
    for (k = 0; k < 20 && eventValid !== 1'b1; k++) tick(1);
    `CHK(eventCode, 4'h6)
    `CHK(eventLevel, 1'b1)
    stampA = eventStamp;
    tick(30 - k);
    reqV = 5'h00;
    `WAITC(eventValid)
    `CHK(eventLevel, 1'b0)
    `CHK(eventStamp - stampA, 32'h3)
    force_lock_in = 1'b0;
    unlock();
    failNext = 1'b1;
    reqV = 5'h01;
    tick(2);
    reqV = 5'h00;
    `WAITC(lockedOut)
    `CHK(lockedOut, 1'b1)
    done("events and failure");
    final_report();
  end
endmodule
